/* src/fsled_top.sv */
/*
 * fieldbus status led encoder: maps card state onto module, network
 * and per-port link leds.
 * assumes all inputs synchronous to clk and state levels held steady.
 */
// What this block does
// R1: two link leds plus four status leds
// R2: module led dark when uninitialised or initialising
// R3: module led steady green when running normally
// R4: module led single green flash on diagnostics
// R5: module led steady red in exception state
// R6: fatal error: module and network leds red
// R7: firmware update alternates module led red/green
// R8: network led dark without controller connection
// R9: network led green when controller connected, running
// R10: single green flash on stop, bad data, sync
// R11: identify request blinks network led green
// R12: fatal error: network red with module red
// R13: no station name: single red flash
// R14: two red no ip, three ident mismatch
// R15: flash timing parameters, fixed condition priority
// R16: controller assigns name before cyclic traffic
`timescale 1ns/1ps
`default_nettype none
`include "fsled_consts.svh"
module fsled_top
   import fsled_pkg::*;
#(
   parameter int TICK_CYCLES = `FSLED_TICK_CYCLES,
   parameter int ON_TICKS = `FSLED_FLASH_ON_TICKS,
   parameter int GAP_TICKS = `FSLED_FLASH_GAP_TICKS,
   parameter int PAUSE_TICKS = `FSLED_GROUP_PAUSE_TICKS,
   parameter int BLINK_TICKS = `FSLED_BLINK_HALF_TICKS,
   parameter int ALT_TICKS = `FSLED_ALT_HALF_TICKS,
   parameter int ACT_TICKS = `FSLED_ACT_STRETCH_TICKS,
   parameter int PORTS = `FSLED_PORTS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic powered_up,
   input wire logic setup_state,
   input wire logic network_initialising_state,
   input wire logic diag_pending,
   input wire logic exception_state,
   input wire logic major_error,
   input wire logic fw_update,
   input wire logic ctrl_connected,
   input wire logic ctrl_stopped,
   input wire logic io_data_bad,
   input wire logic irt_sync_pending,
   input wire logic identify_req,
   input wire logic name_missing,
   input wire logic ip_missing,
   input wire logic ident_mismatch,
   input wire logic [PORTS-1:0] port_link,
   input wire logic [PORTS-1:0] port_activity,
   output logic mod_green,
   output logic mod_red,
   output logic net_green,
   output logic net_red,
   output logic [PORTS-1:0] link_led
);
   fsled_mod_t mod_r, mod_nxt;
   fsled_net_t net_r, net_nxt;
   logic [31:0] div_r;
   logic tick_r;
   logic [15:0] blink_cnt_r;
   logic blink_r;
   logic [15:0] alt_cnt_r;
   logic alt_r;
   logic [1:0] mod_cnt, net_cnt;
   logic mod_flash, net_flash;
   logic [15:0] act_cnt_r [PORTS];
   logic mod_green_r, mod_red_r, net_green_r, net_red_r;
   logic [PORTS-1:0] link_r;

   function automatic logic [15:0] half_step(input logic [15:0] c, input int lim);
      half_step = (c >= 16'(lim - 1)) ? 16'h0000 : c + 16'h0001;
   endfunction

   // ************************************************
   // tick divider and slow blink sources
   // ************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         div_r <= 32'h0000_0000;
         tick_r <= 1'b0;
      end else begin
         tick_r <= (div_r >= 32'(TICK_CYCLES - 1));
         div_r <= (div_r >= 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 : div_r + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || net_r != FSLED_NET_IDENT) begin
         blink_cnt_r <= 16'h0000;
         blink_r <= 1'b1;
      end else if (tick_r) begin
         blink_cnt_r <= half_step(blink_cnt_r, BLINK_TICKS); // see R11
         if (blink_cnt_r >= 16'(BLINK_TICKS - 1)) begin
            blink_r <= ~blink_r;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst || mod_r != FSLED_MOD_FWUPD) begin
         alt_cnt_r <= 16'h0000;
         alt_r <= 1'b0;
      end else if (tick_r) begin
         alt_cnt_r <= half_step(alt_cnt_r, ALT_TICKS); // see R7
         if (alt_cnt_r >= 16'(ALT_TICKS - 1)) begin
            alt_r <= ~alt_r;
         end
      end
   end

   // ************************************************
   // state selection with fixed priority
   // ************************************************
   always_comb begin
      if (!powered_up) begin
         mod_nxt = FSLED_MOD_OFF; // see R2
      end else if (major_error) begin
         mod_nxt = FSLED_MOD_FATAL; // see R6
      end else if (fw_update) begin
         mod_nxt = FSLED_MOD_FWUPD; // see R7
      end else if (exception_state) begin
         mod_nxt = FSLED_MOD_EXC; // see R5
      end else if (setup_state || network_initialising_state) begin
         mod_nxt = FSLED_MOD_OFF; // see R2
      end else if (diag_pending) begin
         mod_nxt = FSLED_MOD_DIAG; // see R4
      end else begin
         mod_nxt = FSLED_MOD_RUN; // see R3
      end
   end

   always_comb begin
      if (!powered_up) begin
         net_nxt = FSLED_NET_OFF; // see R8
      end else if (major_error) begin
         net_nxt = FSLED_NET_FATAL; // see R12
      end else if (identify_req) begin
         net_nxt = FSLED_NET_IDENT; // see R11
      end else if (ident_mismatch) begin
         net_nxt = FSLED_NET_CFG; // see R14
      end else if (ip_missing) begin
         net_nxt = FSLED_NET_IP; // see R14
      end else if (name_missing) begin
         net_nxt = FSLED_NET_NAME; // see R13
      end else if (!ctrl_connected) begin
         net_nxt = FSLED_NET_OFF; // see R8
      end else if (ctrl_stopped || io_data_bad || irt_sync_pending) begin
         net_nxt = FSLED_NET_STOP; // see R10
      end else begin
         net_nxt = FSLED_NET_RUN; // see R9
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mod_r <= FSLED_MOD_OFF;
         net_r <= FSLED_NET_OFF;
      end else begin
         mod_r <= mod_nxt;
         net_r <= net_nxt;
      end
   end

   // ************************************************
   // flash group generators
   // ************************************************
   always_comb begin
      mod_cnt = (mod_r == FSLED_MOD_DIAG) ? 2'h1 : 2'h0; // see R4
      case (net_r)
         FSLED_NET_STOP: net_cnt = 2'h1; // see R10
         FSLED_NET_NAME: net_cnt = 2'h1; // see R13
         FSLED_NET_IP: net_cnt = 2'h2; // see R14
         FSLED_NET_CFG: net_cnt = 2'h3; // see R14
         default: net_cnt = 2'h0;
      endcase
   end

   fsled_flasher #(.ON_TICKS(ON_TICKS), .GAP_TICKS(GAP_TICKS), .PAUSE_TICKS(PAUSE_TICKS))
   u_mod_flash (.clk(clk), .rst(rst), .tick(tick_r), .count(mod_cnt), .lit(mod_flash));

   fsled_flasher #(.ON_TICKS(ON_TICKS), .GAP_TICKS(GAP_TICKS), .PAUSE_TICKS(PAUSE_TICKS))
   u_net_flash (.clk(clk), .rst(rst), .tick(tick_r), .count(net_cnt), .lit(net_flash));

   // ************************************************
   // led drivers
   // ************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         mod_green_r <= 1'b0;
         mod_red_r <= 1'b0;
      end else begin
         case (mod_r)
            FSLED_MOD_OFF: begin
               mod_green_r <= 1'b0; // see R2
               mod_red_r <= 1'b0;
            end
            FSLED_MOD_RUN: begin
               mod_green_r <= 1'b1; // see R3
               mod_red_r <= 1'b0;
            end
            FSLED_MOD_DIAG: begin
               mod_green_r <= mod_flash; // see R4
               mod_red_r <= 1'b0;
            end
            FSLED_MOD_EXC, FSLED_MOD_FATAL: begin
               mod_green_r <= 1'b0; // see R5 R6
               mod_red_r <= 1'b1;
            end
            FSLED_MOD_FWUPD: begin
               mod_green_r <= alt_r; // see R7
               mod_red_r <= ~alt_r;
            end
            default: begin
               mod_green_r <= 1'b0;
               mod_red_r <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         net_green_r <= 1'b0;
         net_red_r <= 1'b0;
      end else begin
         case (net_r)
            FSLED_NET_OFF: begin
               net_green_r <= 1'b0; // see R8
               net_red_r <= 1'b0;
            end
            FSLED_NET_RUN: begin
               net_green_r <= 1'b1; // see R9
               net_red_r <= 1'b0;
            end
            FSLED_NET_STOP: begin
               net_green_r <= net_flash; // see R10
               net_red_r <= 1'b0;
            end
            FSLED_NET_IDENT: begin
               net_green_r <= blink_r; // see R11
               net_red_r <= 1'b0;
            end
            FSLED_NET_FATAL: begin
               net_green_r <= 1'b0; // see R12
               net_red_r <= 1'b1;
            end
            FSLED_NET_NAME, FSLED_NET_IP, FSLED_NET_CFG: begin
               net_green_r <= 1'b0; // see R13 R14
               net_red_r <= net_flash;
            end
            default: begin
               net_green_r <= 1'b0;
               net_red_r <= 1'b0;
            end
         endcase
      end
   end

   // per-port link leds: on with link, blinking while the activity stretch counts down after activity
   always_ff @(posedge clk) begin
      for (int p = 0; p < PORTS; p++) begin
         if (rst) begin
            act_cnt_r[p] <= 16'h0000;
            link_r[p] <= 1'b0;
         end else begin
            if (port_activity[p]) begin
               act_cnt_r[p] <= 16'(ACT_TICKS); // see R1
            end else if (tick_r && act_cnt_r[p] != 16'h0000) begin
               act_cnt_r[p] <= act_cnt_r[p] - 16'h0001;
            end
            link_r[p] <= port_link[p] &&
               (act_cnt_r[p] == 16'h0000 || act_cnt_r[p][`FSLED_ACT_BLINK_BIT]); // see R1
         end
      end
   end

   assign mod_green = mod_green_r;
   assign mod_red = mod_red_r;
   assign net_green = net_green_r;
   assign net_red = net_red_r;
   assign link_led = link_r;
endmodule // fsled_top
`default_nettype wire

/* include/fsled_consts.svh */
/*
 * timing and level constants for the fieldbus status led encoder.
 * assumes a 200 MHz system clock.
 */
`ifndef FSLED_CONSTS_SVH
`define FSLED_CONSTS_SVH
`define FSLED_CLK_HZ 200000000
`define FSLED_TICK_US 1000
`define FSLED_TICK_CYCLES ((`FSLED_CLK_HZ / 1000000) * `FSLED_TICK_US)
`define FSLED_FLASH_ON_TICKS 200
`define FSLED_FLASH_GAP_TICKS 200
`define FSLED_GROUP_PAUSE_TICKS 1000
`define FSLED_BLINK_HALF_TICKS 500
`define FSLED_ALT_HALF_TICKS 500
`define FSLED_PORTS 2
`define FSLED_ACT_STRETCH_TICKS 50
`define FSLED_ACT_BLINK_BIT 2
`endif

/* include/fsled_pkg.sv */
/*
 * types for the fieldbus status led encoder.
 * assumes nothing beyond the tool's package support.
 */
package fsled_pkg;
   typedef enum logic [5:0] {
      FSLED_MOD_OFF = 6'b00_0001,
      FSLED_MOD_RUN = 6'b00_0010,
      FSLED_MOD_DIAG = 6'b00_0100,
      FSLED_MOD_EXC = 6'b00_1000,
      FSLED_MOD_FATAL = 6'b01_0000,
      FSLED_MOD_FWUPD = 6'b10_0000
   } fsled_mod_t;
   typedef enum logic [7:0] {
      FSLED_NET_OFF = 8'b0000_0001,
      FSLED_NET_RUN = 8'b0000_0010,
      FSLED_NET_STOP = 8'b0000_0100,
      FSLED_NET_IDENT = 8'b0000_1000,
      FSLED_NET_FATAL = 8'b0001_0000,
      FSLED_NET_NAME = 8'b0010_0000,
      FSLED_NET_IP = 8'b0100_0000,
      FSLED_NET_CFG = 8'b1000_0000
   } fsled_net_t;
endpackage

/* src/fsled_flasher.sv */
/*
 * flash group generator: repeats a group of n flashes then a pause.
 * assumes a one-cycle tick enable from the parent.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fsled_consts.svh"
module fsled_flasher #(
   parameter int ON_TICKS = `FSLED_FLASH_ON_TICKS,
   parameter int GAP_TICKS = `FSLED_FLASH_GAP_TICKS,
   parameter int PAUSE_TICKS = `FSLED_GROUP_PAUSE_TICKS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic [1:0] count,
   output logic lit
);
   logic [15:0] t_r;
   logic [1:0] n_r;
   logic on_r;
   // ************************************************
   // flash sequencing
   // ************************************************
   always_ff @(posedge clk) begin
      if (rst || count == 2'h0) begin
         t_r <= 16'h0000;
         n_r <= 2'h0;
         on_r <= 1'b0;
      end else if (tick) begin
         if (on_r) begin
            if (t_r >= 16'(ON_TICKS - 1)) begin // see R15
               on_r <= 1'b0;
               n_r <= n_r + 2'h1;
               t_r <= 16'h0000;
            end else begin
               t_r <= t_r + 16'h0001;
            end
         end else if (n_r >= count) begin
            if (t_r >= 16'(PAUSE_TICKS - 1)) begin // see R15
               n_r <= 2'h0;
               t_r <= 16'h0000;
            end else begin
               t_r <= t_r + 16'h0001;
            end
         end else if (n_r == 2'h0 || t_r >= 16'(GAP_TICKS - 1)) begin // see R15
            on_r <= 1'b1;
            t_r <= 16'h0000;
         end else begin
            t_r <= t_r + 16'h0001;
         end
      end
   end
   assign lit = on_r;
endmodule // fsled_flasher
`default_nettype wire

/* sim/fsled_lamp.sv */
/* operator's view of one front panel lamp: counts flashes per group.
   assumes lit is sampled on clk; fifteen dark cycles close a group. */
`timescale 1ns/1ps
`default_nettype none
module fsled_lamp (
   input wire logic clk,
   input wire logic rst,
   input wire logic lit,
   output var int burst,
   output var int rises
);
   // ****
   // flash counting
   // ****
   int cnt;
   int dark;
   logic last;
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt <= 0;
         dark <= 0;
         last <= 1'h0;
         burst <= 0;
         rises <= 0;
      end else begin
         last <= lit;
         dark <= lit ? 0 : dark + 1;
         if (lit && !last) begin
            cnt <= cnt + 1;
            rises <= rises + 1;
         end
         if (!lit && dark == 14) begin
            burst <= cnt;
            cnt <= 0;
         end
      end
   end
endmodule // fsled_lamp
`default_nettype wire

/* sim/fsled_top_properties.sv */
/* checker for fsled_top: led patterns for each card state except setup, diagnostics, stop and identify.
   assumes a bind by name from the bench. */
`timescale 1ns/1ps
`default_nettype none
module fsled_top_properties (
   input wire logic clk,
   input wire logic rst,
   input wire logic powered_up,
   input wire logic setup_state,
   input wire logic network_initialising_state,
   input wire logic diag_pending,
   input wire logic exception_state,
   input wire logic major_error,
   input wire logic fw_update,
   input wire logic ctrl_connected,
   input wire logic ctrl_stopped,
   input wire logic io_data_bad,
   input wire logic irt_sync_pending,
   input wire logic identify_req,
   input wire logic name_missing,
   input wire logic ip_missing,
   input wire logic ident_mismatch,
   input wire logic mod_green,
   input wire logic mod_red,
   input wire logic net_green,
   input wire logic net_red
);
   // ****
   // state qualifiers
   // ****
   wire m_on = powered_up && !major_error;
   wire m_ok = m_on && !fw_update && !exception_state && !setup_state;
   wire n_on = m_on && !identify_req;
   wire n_ok = n_on && !ident_mismatch && !ip_missing && !name_missing;
   wire n_go = n_ok && ctrl_connected && !ctrl_stopped && !io_data_bad && !irt_sync_pending;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   chk_unpowered_dark: assert property (
      !powered_up [*2] |=> !(mod_green || mod_red || net_green || net_red))
      else $error("status led lit while unpowered");
   chk_fatal_red: assert property (
      (powered_up && major_error) [*2] |=> mod_red && net_red && !mod_green && !net_green)
      else $error("fatal error not shown red on both leds");
   chk_init_dark: assert property (
      (m_ok && network_initialising_state) [*2] |=> !mod_green && !mod_red)
      else $error("module led lit while initialising");
   chk_mod_run: assert property (
      (m_ok && !network_initialising_state && !diag_pending) [*2] |=> mod_green && !mod_red)
      else $error("module led not steady green");
   chk_exc_red: assert property (
      (m_on && !fw_update && exception_state) [*2] |=> mod_red && !mod_green)
      else $error("exception not steady red");
   chk_fw_alternate: assert property (
      (m_on && fw_update) [*2] |=> mod_red != mod_green)
      else $error("firmware update not one colour at a time");
   chk_net_dark: assert property (
      (n_ok && !ctrl_connected) [*2] |=> !net_green && !net_red)
      else $error("network led lit without controller");
   chk_net_run: assert property (
      n_go [*2] |=> net_green && !net_red)
      else $error("network led not steady green");
   chk_net_fault: assert property (
      (n_on && (name_missing || ip_missing || ident_mismatch)) [*2] |=> !net_green)
      else $error("network fault flash shows green");
   cov_fatal: cover property (major_error && mod_red && net_red);
   cov_fw: cover property (fw_update && mod_green);
   cov_ident: cover property (identify_req && net_green);
endmodule // fsled_top_properties
`default_nettype wire

/* sim/fsled_top_bench.sv */
/* bench for fsled_top: drives card state at the falling edge and judges
   the leds directly and through four lamp observers. */
`timescale 1ns/1ps
`default_nettype none
bind fsled_top fsled_top_properties u_chk (.clk(clk), .rst(rst), .powered_up(powered_up),
   .setup_state(setup_state), .network_initialising_state(network_initialising_state),
   .diag_pending(diag_pending), .exception_state(exception_state), .major_error(major_error),
   .fw_update(fw_update), .ctrl_connected(ctrl_connected), .ctrl_stopped(ctrl_stopped),
   .io_data_bad(io_data_bad), .irt_sync_pending(irt_sync_pending),
   .identify_req(identify_req), .name_missing(name_missing), .ip_missing(ip_missing),
   .ident_mismatch(ident_mismatch), .mod_green(mod_green), .mod_red(mod_red),
   .net_green(net_green), .net_red(net_red));
module fsled_top_bench;
   // ****
   // stimulus and observers
   // ****
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic pw, su, ni, dg, ex, me, fw, cc, cs, ib, is, ir, nm, im, mm;
   logic [1:0] pl;
   logic [1:0] pa;
   logic mg, mr, ng, nr;
   logic [1:0] ll;
   wire [3:0] leds = {mg, mr, ng, nr};
   int mg_b, mg_r, mr_b, mr_r, ng_b, ng_r, nr_b, nr_r, r0, r1;
   int errors = 0;
   int samples_checked = 0;
   logic seen;
   logic [5:0] net_case [7] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01, 6'h07};
   int net_n [7] = '{1, 1, 1, 1, 2, 3, 3};
   initial {pw, su, ni, dg, ex, me, fw, cc, cs, ib, is, ir, nm, im, mm, pl, pa} = 19'h0_0000;
   initial begin
      forever #2.5 clk = ~clk;
   end
   fsled_top #(.TICK_CYCLES(4), .ON_TICKS(2), .GAP_TICKS(2), .PAUSE_TICKS(5),
      .ALT_TICKS(3)) i_dut (.clk(clk), .rst(rst), .powered_up(pw),
      .setup_state(su), .network_initialising_state(ni), .diag_pending(dg),
      .exception_state(ex), .major_error(me), .fw_update(fw), .ctrl_connected(cc),
      .ctrl_stopped(cs), .io_data_bad(ib), .irt_sync_pending(is), .identify_req(ir),
      .name_missing(nm), .ip_missing(im), .ident_mismatch(mm), .port_link(pl),
      .port_activity(pa), .mod_green(mg), .mod_red(mr), .net_green(ng), .net_red(nr),
      .link_led(ll));
   fsled_lamp u_mg (.clk(clk), .rst(rst), .lit(mg), .burst(mg_b), .rises(mg_r));
   fsled_lamp u_mr (.clk(clk), .rst(rst), .lit(mr), .burst(mr_b), .rises(mr_r));
   fsled_lamp u_ng (.clk(clk), .rst(rst), .lit(ng), .burst(ng_b), .rises(ng_r));
   fsled_lamp u_nr (.clk(clk), .rst(rst), .lit(nr), .burst(nr_b), .rises(nr_r));
   // ****
   // shared tasks
   // ****
   task automatic go(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %0t got %0h want %0h", $time, g, e);
      end
   endtask
   task automatic print_verdict;
      if (errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic start;
      @(negedge clk);
      rst = 1'h1;
      {pw, su, ni, dg, ex, me, fw, cc} = 8'h81;
      {cs, ib, is, ir, nm, im, mm, pl, pa} = 11'h000;
      go(2);
      rst = 1'h0;
      go(1);
   endtask
   task automatic steady(input logic [3:0] e);
      go(4);
      repeat (20) begin
         @(negedge clk);
         cmp(leds, e);
      end
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_unpowered;
      start;
      pw = 1'h0;
      me = 1'h1;
      steady(4'h0);
   endtask
   task automatic t_mod;
      start;
      ni = 1'h1;
      steady(4'h2);
      ni = 1'h0;
      su = 1'h1;
      steady(4'h2);
      su = 1'h0;
      steady(4'hA);
      ex = 1'h1;
      dg = 1'h1;
      steady(4'h6);
   endtask
   task automatic t_fatal;
      start;
      me = 1'h1;
      fw = 1'h1;
      ir = 1'h1;
      nm = 1'h1;
      steady(4'h5);
   endtask
   task automatic t_fw;
      start;
      fw = 1'h1;
      ex = 1'h1;
      go(4);
      r0 = mr_r;
      r1 = mg_r;
      go(100);
      cmp(mr_r - r0 > 1, 1);
      cmp(mg_r - r1 > 1, 1);
   endtask
   task automatic t_diag;
      start;
      dg = 1'h1;
      go(200);
      cmp(mg_b, 1);
   endtask
   task automatic t_net;
      for (int i = 0; i < 7; i++) begin
         start;
         {cs, ib, is, nm, im, mm} = net_case[i];
         go(200);
         cmp(i < 3 ? ng_b : nr_b, net_n[i]);
      end
   endtask
   task automatic t_ident;
      start;
      ir = 1'h1;
      nm = 1'h1;
      go(4);
      r0 = ng_r;
      r1 = nr_r;
      go(14000);
      cmp(ng_r - r0 > 2, 1);
      cmp(nr_r - r1, 0);
   endtask
   task automatic t_offline;
      start;
      cc = 1'h0;
      cs = 1'h1;
      steady(4'h8);
   endtask
   task automatic t_link;
      start;
      pl = 2'h1;
      go(6);
      cmp(ll, 2'h1);
      pl = 2'h3;
      pa = 2'h2;
      go(1);
      pa = 2'h0;
      seen = 1'h0;
      repeat (60) begin
         @(negedge clk);
         if (ll[1] === 1'h0) seen = 1'h1;
      end
      cmp(seen, 1);
      cmp(ll[0], 1);
   endtask
   initial begin
      go(8);
      rst = 1'h0;
      go(1);
      cmp(leds, 4'h0);
      t_unpowered;
      t_mod;
      t_fatal;
      t_fw;
      t_diag;
      t_net;
      t_ident;
      t_offline;
      t_link;
      print_verdict;
   end
endmodule // fsled_top_bench
`default_nettype wire
